/* File: hw/accel_i2c_pkg.sv */
// Constants, state encodings and the state record of the two-wire target port.
// Assumes a single 50 MHz system clock that oversamples the bus pins.
package accel_i2c_pkg;

    // Seven-bit target addresses picked by the address-select pin.
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h1D;
    localparam logic [6:0] ADDR_SEL_LOW  = 7'h53;

    // Bus rates that the port is built to follow.
    localparam int STD_RATE_HZ  = 100000;
    localparam int FAST_RATE_HZ = 400000;
    localparam int MCLK_HZ      = 50000000;
    // System clocks in half a fast-mode bus period, rounded down.
    localparam int FAST_HALF_CYCLES = MCLK_HZ / (2 * FAST_RATE_HZ);

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_ZERO      = 4'h0;
    localparam logic [3:0] BIT_STEP      = 4'h1;
    localparam logic [7:0] PTR_STEP      = 8'h01;
    localparam logic [7:0] PTR_RESET     = 8'h00;
    localparam int         RW_BIT        = 0;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_RACK = 5'h10
    } port_state_e;

    typedef enum logic [2:0] {
        K_ADDR = 3'h1,
        K_PTR  = 3'h2,
        K_DATA = 3'h4
    } byte_kind_e;

    typedef struct packed {
        logic        sclS1;
        logic        sclS2;
        logic        sclD;
        logic        sdaS1;
        logic        sdaS2;
        logic        sdaD;
        logic        selS1;
        logic        selS2;
        logic        altS1;
        logic        altS2;
        port_state_e state;
        byte_kind_e  kind;
        logic [3:0]  bitCnt;
        logic [7:0]  shift;
        logic        readMode;
        logic        nack;
        logic        sdaLow;
        logic [7:0]  pointer;
        logic [7:0]  wrData;
        logic        wrStrobe;
        logic        rdStrobe;
    } port_regs_s;

endpackage

/* File: hw/accel_i2c_target_port.sv */
// Two-wire serial target port that reaches the sensor's register space.
// Assumes bus pins and select pins arrive asynchronously, and that the
// register space answers regRdData combinationally from regAddr on mclk.
//
// Notes on behaviour
// - Interface-select high makes the port a bus target.
// - Serve standard and fast rates; controller stays below.
// - Single and multiple byte reads and writes work.
// - Select pin high answers address 0x1D.
// - Select pin low answers address 0x53.
// - Read phase follows repeated start or stop-start.
// - While selected, any start begins a transaction.
`timescale 1ns/10ps
module accel_i2c_target_port
    import accel_i2c_pkg::*;
(
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Mode pins.
    input  wire logic       interfaceSelect,
    input  wire logic       targetAddressSelect,
    // Two-wire bus.
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOeN,
    // Register space.
    output logic [7:0]      regAddr,
    output logic [7:0]      regWrData,
    output logic            regWrStrobe,
    output logic            regRdStrobe,
    input  wire logic [7:0] regRdData
);

    port_regs_s st;
    port_regs_s next_st;

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic [6:0] ownAddr;

    function automatic logic [3:0] bitInc(input logic [3:0] n);
        return n + BIT_STEP;
    endfunction

    assign sclRise   = st.sclS2 & ~st.sclD;
    assign sclFall   = ~st.sclS2 & st.sclD;
    assign startCond = st.sclS2 & st.sclD & st.sdaD & ~st.sdaS2;
    assign stopCond  = st.sclS2 & st.sclD & ~st.sdaD & st.sdaS2;
    assign ownAddr   = st.altS2 ? ADDR_SEL_HIGH : ADDR_SEL_LOW;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_st = st;
        next_st.sclS1 = sclIn;
        next_st.sclS2 = st.sclS1;
        next_st.sclD  = st.sclS2;
        next_st.sdaS1 = sdaIn;
        next_st.sdaS2 = st.sdaS1;
        next_st.sdaD  = st.sdaS2;
        next_st.selS1 = interfaceSelect;
        next_st.selS2 = st.selS1;
        next_st.altS1 = targetAddressSelect;
        next_st.altS2 = st.altS1;
        next_st.wrStrobe = 1'b0;
        next_st.rdStrobe = 1'b0;

        if (!st.selS2) begin
            next_st.state  = ST_IDLE;
            next_st.sdaLow = 1'b0;
        end else if (startCond) begin
            // A repeated start lands here from any state.
            next_st.state  = ST_RX;
            next_st.kind   = K_ADDR;
            next_st.bitCnt = BIT_ZERO;
            next_st.sdaLow = 1'b0;
        end else if (stopCond) begin
            // The pointer survives a stop so that stop-start reads continue.
            next_st.state  = ST_IDLE;
            next_st.sdaLow = 1'b0;
        end else begin
            unique case (st.state)
                ST_IDLE: begin
                end
                ST_RX: begin
                    if (sclRise) begin
                        next_st.shift  = {st.shift[6:0], st.sdaS2};
                        next_st.bitCnt = bitInc(st.bitCnt);
                    end else if (sclFall && st.bitCnt == BITS_PER_BYTE) begin
                        next_st.bitCnt = BIT_ZERO;
                        if (st.kind == K_ADDR) begin
                            if (st.shift[7:1] == ownAddr) begin
                                next_st.readMode = st.shift[RW_BIT];
                                next_st.sdaLow   = 1'b1;
                                next_st.state    = ST_ACK;
                            end else begin
                                next_st.state = ST_IDLE;
                            end
                        end else if (st.kind == K_PTR) begin
                            next_st.pointer = st.shift;
                            next_st.sdaLow  = 1'b1;
                            next_st.state   = ST_ACK;
                        end else begin
                            next_st.wrData   = st.shift;
                            next_st.wrStrobe = 1'b1;
                            next_st.sdaLow   = 1'b1;
                            next_st.state    = ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        next_st.bitCnt = BIT_ZERO;
                        if (st.kind == K_ADDR && st.readMode) begin
                            next_st.shift    = {regRdData[6:0], 1'b0};
                            next_st.sdaLow   = ~regRdData[7];
                            next_st.rdStrobe = 1'b1;
                            next_st.pointer  = st.pointer + PTR_STEP;
                            next_st.state    = ST_TX;
                        end else begin
                            next_st.sdaLow = 1'b0;
                            next_st.state  = ST_RX;
                            if (st.kind == K_ADDR) begin
                                next_st.kind = K_PTR;
                            end else if (st.kind == K_PTR) begin
                                next_st.kind = K_DATA;
                            end else begin
                                next_st.pointer = st.pointer + PTR_STEP;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (sclRise) begin
                        next_st.bitCnt = bitInc(st.bitCnt);
                    end else if (sclFall) begin
                        if (st.bitCnt == BITS_PER_BYTE) begin
                            next_st.sdaLow = 1'b0;
                            next_st.state  = ST_RACK;
                        end else begin
                            next_st.sdaLow = ~st.shift[7];
                            next_st.shift  = {st.shift[6:0], 1'b0};
                        end
                    end
                end
                ST_RACK: begin
                    if (sclRise) begin
                        next_st.nack = st.sdaS2;
                    end else if (sclFall) begin
                        next_st.bitCnt = BIT_ZERO;
                        if (st.nack) begin
                            next_st.state = ST_IDLE;
                        end else begin
                            next_st.shift    = {regRdData[6:0], 1'b0};
                            next_st.sdaLow   = ~regRdData[7];
                            next_st.rdStrobe = 1'b1;
                            next_st.pointer  = st.pointer + PTR_STEP;
                            next_st.state    = ST_TX;
                        end
                    end
                end
                default: begin
                    next_st.state  = ST_IDLE;
                    next_st.sdaLow = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.sclS1    <= 1'b1;
            st.sclS2    <= 1'b1;
            st.sclD     <= 1'b1;
            st.sdaS1    <= 1'b1;
            st.sdaS2    <= 1'b1;
            st.sdaD     <= 1'b1;
            st.state    <= ST_IDLE;
            st.kind     <= K_ADDR;
            st.pointer  <= PTR_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // The pin is only ever pulled low; the enable is active low.
    assign sdaOut      = 1'b0;
    assign sdaOeN      = ~st.sdaLow;
    assign regAddr     = st.pointer;
    assign regWrData   = st.wrData;
    assign regWrStrobe = st.wrStrobe;
    assign regRdStrobe = st.rdStrobe;

    ////////////////////////////////////////////////////////////////////////////////

    property p_deselectIdle;
        @(posedge mclk) disable iff (!rst_n)
        !st.selS2 |=> (st.state == ST_IDLE) && sdaOeN;
    endproperty
    a_deselectIdle: assert property (p_deselectIdle) else $error("port active while deselected");

    property p_sdaMovesWhileSclLow;
        @(posedge mclk) disable iff (!rst_n)
        $changed(sdaOeN) && !startCond && !stopCond && st.selS2 |-> !st.sclS2;
    endproperty
    a_sdaMovesWhileSclLow: assert property (p_sdaMovesWhileSclLow) else $error("sda moved with scl high");

    property p_readAdvances;
        @(posedge mclk) disable iff (!rst_n)
        regRdStrobe |-> regAddr == $past(regAddr) + PTR_STEP;
    endproperty
    a_readAdvances: assert property (p_readAdvances) else $error("read pointer did not advance");

    property p_ackHigh;
        @(posedge mclk) disable iff (!rst_n)
        st.selS2 && !startCond && !stopCond && st.state == ST_RX && st.kind == K_ADDR
        && sclFall && st.bitCnt == BITS_PER_BYTE && st.altS2
        |=> (st.shift[7:1] == ADDR_SEL_HIGH) == !sdaOeN;
    endproperty
    a_ackHigh: assert property (p_ackHigh) else $error("wrong answer to high address");

    property p_ackLow;
        @(posedge mclk) disable iff (!rst_n)
        st.selS2 && !startCond && !stopCond && st.state == ST_RX && st.kind == K_ADDR
        && sclFall && st.bitCnt == BITS_PER_BYTE && !st.altS2
        |=> (st.shift[7:1] == ADDR_SEL_LOW) == !sdaOeN;
    endproperty
    a_ackLow: assert property (p_ackLow) else $error("wrong answer to low address");

    property p_stopKeepsPointer;
        @(posedge mclk) disable iff (!rst_n)
        st.selS2 && stopCond |=> (st.state == ST_IDLE) && $stable(regAddr);
    endproperty
    a_stopKeepsPointer: assert property (p_stopKeepsPointer) else $error("stop lost pointer");

    property p_startBegins;
        @(posedge mclk) disable iff (!rst_n)
        st.selS2 && startCond |=> st.state == ST_RX && st.kind == K_ADDR && st.bitCnt == BIT_ZERO;
    endproperty
    a_startBegins: assert property (p_startBegins) else $error("start not taken");

    property p_writeAdvances;
        @(posedge mclk) disable iff (!rst_n)
        st.state == ST_ACK && st.kind == K_DATA && sclFall
        && st.selS2 && !startCond && !stopCond
        |=> regAddr == $past(regAddr) + PTR_STEP;
    endproperty
    a_writeAdvances: assert property (p_writeAdvances) else $error("write pointer stuck");

endmodule

/* File: tb/i2c_bus_controller.sv */
// Behavioural two-wire bus controller that drives the target port's far side.
// Assumes an open-drain wire resolved by the bench with a pull-up to high.
`timescale 1ns/10ps
module i2c_bus_controller (
    output logic      scl,
    output logic      sdaDrv,
    input  wire logic sdaWire
);
    localparam int QTR = 40;
    initial begin
        scl    = 1'b1;
        sdaDrv = 1'b1;
    end
    // Level 0 makes a start or repeated start, level 1 a stop; clock idles high after stop.
    task automatic cond(input logic lvl);
        sdaDrv = ~lvl;
        #QTR;
        scl = 1'b1;
        #(2 * QTR);
        sdaDrv = lvl;
        #(2 * QTR);
        if (!lvl) begin
            scl = 1'b0;
            #QTR;
        end
    endtask
    task automatic putBit(input logic b);
        sdaDrv = b;
        #QTR;
        scl = 1'b1;
        #(2 * QTR);
        scl = 1'b0;
        #QTR;
    endtask
    // Sampling late in the high phase leaves room for the target's synchroniser delay.
    task automatic getBit(output logic b);
        sdaDrv = 1'b1;
        #QTR;
        scl = 1'b1;
        #60;
        b = sdaWire;
        #20;
        scl = 1'b0;
        #QTR;
    endtask
    task automatic writeByte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            putBit(d[i]);
        end
        getBit(b);
        ack = ~b;
    endtask
    task automatic readByte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            getBit(d[i]);
        end
        putBit(last);
    endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench of the two-wire target port with a register-space model.
// Assumes the controller model in its own file and the design package.
`timescale 1ns/10ps
module tb;
    import accel_i2c_pkg::*;
    logic       mclk;
    logic       rst_n;
    logic       interfaceSelect;
    logic       targetAddressSelect;
    logic       scl;
    logic       sdaDrv;
    logic       sdaOut;
    logic       sdaOeN;
    logic       regWrStrobe;
    logic       regRdStrobe;
    logic       ack;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] d;
    logic [7:0] rdCount;
    logic [7:0] mem [256];
    int         num_errors;
    int         checked;
    wire        sdaWire = sdaDrv & (sdaOeN | sdaOut);
    wire  [7:0] regRdData = mem[regAddr];
    localparam logic [7:0] HW = {ADDR_SEL_HIGH, 1'b0};
    localparam logic [7:0] LW = {ADDR_SEL_LOW, 1'b0};

    accel_i2c_target_port dut (
        .mclk(mclk), .rst_n(rst_n), .interfaceSelect(interfaceSelect),
        .targetAddressSelect(targetAddressSelect), .sclIn(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData)
    );
    i2c_bus_controller ctl (.scl(scl), .sdaDrv(sdaDrv), .sdaWire(sdaWire));

    always @(posedge mclk) begin
        if (regWrStrobe === 1'b1) begin
            mem[regAddr] <= regWrData;
        end
        if (regRdStrobe === 1'b1) begin
            rdCount <= rdCount + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkAck(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t ack=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic setPins(input logic sel, input logic alt);
        @(negedge mclk);
        interfaceSelect     = sel;
        targetAddressSelect = alt;
        repeat (4) @(negedge mclk);
    endtask
    task automatic results;
        $display("Checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic multiWriteReadSr;
        setPins(1'b1, 1'b1);
        ctl.cond(1'b0);
        ctl.writeByte(HW, ack);
        chkAck(ack, 1'b1);
        ctl.writeByte(8'h10, ack);
        ctl.writeByte(8'hA5, ack);
        ctl.writeByte(8'h5A, ack);
        chkAck(ack, 1'b1);
        ctl.cond(1'b1);
        chk8(mem[8'h10], 8'hA5);
        chk8(mem[8'h11], 8'h5A);
        chk8(mem[8'h12], 8'hED);
        ctl.cond(1'b0);
        ctl.writeByte(HW, ack);
        ctl.writeByte(8'h10, ack);
        ctl.cond(1'b0);
        ctl.writeByte(HW | 8'h01, ack);
        chkAck(ack, 1'b1);
        ctl.readByte(1'b0, d);
        chk8(d, 8'hA5);
        ctl.readByte(1'b1, d);
        chk8(d, 8'h5A);
        ctl.cond(1'b1);
        chk8(rdCount, 8'h02);
        chk8(regAddr, 8'h12);
    endtask
    task automatic lowAddrStopStart;
        setPins(1'b1, 1'b0);
        ctl.cond(1'b0);
        ctl.writeByte(HW, ack);
        chkAck(ack, 1'b0);
        ctl.cond(1'b1);
        ctl.cond(1'b0);
        ctl.writeByte(LW, ack);
        chkAck(ack, 1'b1);
        ctl.writeByte(8'h12, ack);
        ctl.writeByte(8'hC3, ack);
        ctl.cond(1'b1);
        chk8(mem[8'h12], 8'hC3);
        ctl.cond(1'b0);
        ctl.writeByte(LW, ack);
        ctl.writeByte(8'h11, ack);
        ctl.cond(1'b1);
        ctl.cond(1'b0);
        ctl.writeByte(LW | 8'h01, ack);
        chkAck(ack, 1'b1);
        ctl.readByte(1'b1, d);
        chk8(d, 8'h5A);
        ctl.cond(1'b1);
        chk8(rdCount, 8'h03);
    endtask
    task automatic deselectAndWrongAddr;
        setPins(1'b0, 1'b1);
        ctl.cond(1'b0);
        ctl.writeByte(HW, ack);
        chkAck(ack, 1'b0);
        ctl.cond(1'b1);
        setPins(1'b1, 1'b1);
        ctl.cond(1'b0);
        ctl.writeByte(LW, ack);
        chkAck(ack, 1'b0);
        ctl.cond(1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #300000;
        num_errors++;
        results();
    end
    initial begin
        rst_n               = 1'b0;
        interfaceSelect     = 1'b1;
        targetAddressSelect = 1'b1;
        num_errors          = 0;
        checked             = 0;
        rdCount             = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = ~i[7:0];
        end
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        multiWriteReadSr();
        lowAddrStopStart();
        deselectAndWrongAddr();
        results();
    end
endmodule
